//--- design/scf_pkg.sv
// package: constants and carrier types for the supply code and bus frequency select block
package scf_pkg;
	localparam int SCF_CODE_W = 5;
	localparam int SCF_SEL_W = 2;
	localparam int SCF_CLK_MHZ = 100;
	localparam int SCF_SETTLE_NS = 200;
	localparam int SCF_SETTLE_CYC = (SCF_SETTLE_NS * SCF_CLK_MHZ + 999) / 1000;
	localparam logic [4:0] SCF_CODE_RST = 5'h1f;
	localparam logic [4:0] SCF_CODE_DEF = 5'h08;
	localparam logic [1:0] SCF_SEL_100 = 2'h1;
	localparam logic [1:0] SCF_SEL_RST = 2'h3;
	localparam logic [3:0] SCF_ADDR_CODE = 4'h0;
	localparam logic [3:0] SCF_ADDR_SEL = 4'h1;
	localparam logic [3:0] SCF_ADDR_STAT = 4'h2;
	localparam logic [3:0] SCF_ADDR_PINS = 4'h3;
	localparam logic [31:0] SCF_UNMAPPED = 32'h0;

	typedef enum logic [1:0] {
		SCF_ST_IDLE = 2'b00,
		SCF_ST_SETTLE = 2'b01,
		SCF_ST_LOCKED = 2'b10
	} scf_state_t;

	typedef struct packed {
		logic [4:0] code_oe;
		logic [1:0] sel_oe;
	} scf_pins_t;

	typedef struct packed {
		scf_state_t st;
		logic [7:0] cnt;
		logic [4:0] code_cfg;
		logic [1:0] sel_cfg;
		logic [4:0] code_drv;
		logic [1:0] sel_drv;
		logic stable;
		logic sel_err;
		logic [31:0] rdata;
	} scf_state_reg_t;
endpackage : scf_pkg

//--- design/scf_od_pin.sv
// module: open-drain output pins, one per bit
`timescale 1ns/1ps
module scf_od_pin #(
	parameter int WIDTH = 5
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// wanted level per bit
	input wire logic [WIDTH-1:0] level,
	// pin drive
	output logic [WIDTH-1:0] pin_o,
	output logic [WIDTH-1:0] pin_oe
);
	logic [WIDTH-1:0] oe_r;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// a zero pulls to ground, a one lets the pull-up win
			always_ff @(posedge sys_clk or posedge reset) begin
				if (reset) begin
					oe_r[i] <= 1'b0;
				end else begin
					oe_r[i] <= ~level[i];
				end
			end
		end
	endgenerate
	assign pin_oe = oe_r;
	assign pin_o = '0;
endmodule : scf_od_pin

//--- design/scf_supply_code.sv
// module: supply code and bus frequency select drivers qualified by the termination supply good
`timescale 1ns/1ps
module scf_supply_code
	import scf_pkg::*;
#(
	parameter int SETTLE = SCF_SETTLE_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// termination supply good, already in this clock domain
	input wire logic term_supply_good,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// open-drain supply code, bit 4 is fine_step_bit
	output logic [4:0] supply_code_o,
	output logic [4:0] supply_code_oe,
	// open-drain bus frequency select
	output logic [1:0] bus_freq_select_o,
	output logic [1:0] bus_freq_select_oe,
	// codes are final
	output logic codes_stable
);
	scf_state_reg_t s_r;
	scf_state_reg_t s_nxt;
	logic [6:0] lvl;
	logic [6:0] pin_oe;
	logic [6:0] pin_o;

	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = SCF_UNMAPPED;
		case (s_r.st)
			SCF_ST_IDLE: begin
				// codes are free to settle before supply good; config still accepted
				s_nxt.code_drv = s_r.code_cfg;
				s_nxt.sel_drv = s_r.sel_cfg;
				s_nxt.cnt = 8'h0;
				if (term_supply_good) begin
					s_nxt.st = SCF_ST_SETTLE;
				end
			end
			SCF_ST_SETTLE: begin
				// hold the codes frozen from the moment supply good rises
				if (!term_supply_good) begin
					s_nxt.st = SCF_ST_IDLE;
				end else if (s_r.cnt >= 8'(SETTLE - 1)) begin
					s_nxt.st = SCF_ST_LOCKED;
				end else begin
					s_nxt.cnt = s_r.cnt + 8'h1;
				end
			end
			SCF_ST_LOCKED: begin
				// codes never move while supply good stays high
				if (!term_supply_good) begin
					s_nxt.st = SCF_ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = SCF_ST_IDLE;
			end
		endcase
		s_nxt.stable = (s_nxt.st != SCF_ST_IDLE);
		if (reg_wr) begin
			case (reg_addr)
				SCF_ADDR_CODE: begin
					s_nxt.code_cfg = reg_wdata[4:0];
				end
				SCF_ADDR_SEL: begin
					// reserved patterns refused, the 100 MHz code is kept
					if (reg_wdata[1:0] == SCF_SEL_100) begin
						s_nxt.sel_cfg = reg_wdata[1:0];
					end else begin
						s_nxt.sel_err = 1'b1;
					end
				end
				SCF_ADDR_STAT: begin
					// write one to clear the refused-select flag
					if (reg_wdata[1]) begin
						s_nxt.sel_err = 1'b0;
					end
				end
				default: begin
				end
			endcase
			// a refusal in the same cycle as the clear still sets the flag
			if (reg_addr == SCF_ADDR_SEL && reg_wdata[1:0] != SCF_SEL_100) begin
				s_nxt.sel_err = 1'b1;
			end
		end
		if (reg_rd) begin
			case (reg_addr)
				SCF_ADDR_CODE: s_nxt.rdata = {27'h0, s_r.code_cfg};
				SCF_ADDR_SEL: s_nxt.rdata = {30'h0, s_r.sel_cfg};
				SCF_ADDR_STAT: s_nxt.rdata = {28'h0, s_r.st, s_r.sel_err, s_r.stable};
				SCF_ADDR_PINS: s_nxt.rdata = {25'h0, s_r.sel_drv, s_r.code_drv};
				default: s_nxt.rdata = SCF_UNMAPPED;
			endcase
		end
	end

	// single clock domain; no interrupt or test port lives in this block
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_r.st <= SCF_ST_IDLE;
			s_r.cnt <= 8'h0;
			s_r.code_cfg <= SCF_CODE_DEF;
			s_r.sel_cfg <= SCF_SEL_100;
			s_r.code_drv <= SCF_CODE_RST;
			s_r.sel_drv <= SCF_SEL_RST;
			s_r.stable <= 1'b0;
			s_r.sel_err <= 1'b0;
			s_r.rdata <= 32'h0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// bits are released at reset so the pull-ups set the levels meanwhile
	assign lvl = {s_r.sel_drv, s_r.code_drv};

	// the device is the only driver of both codes
	scf_od_pin #(
		.WIDTH(SCF_CODE_W + SCF_SEL_W)
	) u_pins (
		.sys_clk(sys_clk),
		.reset(reset),
		.level(lvl),
		.pin_o(pin_o),
		.pin_oe(pin_oe)
	);

	assign supply_code_o = pin_o[4:0];
	assign supply_code_oe = pin_oe[4:0];
	assign bus_freq_select_o = pin_o[6:5];
	assign bus_freq_select_oe = pin_oe[6:5];
	assign codes_stable = s_r.stable;
	assign reg_rdata = s_r.rdata;
endmodule : scf_supply_code

//--- verif/scf_supply_code_sva.sv
// checker: port properties of the supply code block
`timescale 1ns/1ps
module scf_supply_code_sva (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// watched ports
	input wire logic term_supply_good,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [4:0] supply_code_o,
	input wire logic [4:0] supply_code_oe,
	input wire logic [1:0] bus_freq_select_o,
	input wire logic [1:0] bus_freq_select_oe,
	input wire logic codes_stable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_code_od; supply_code_o == 5'h0; endproperty
	a_code_od: assert property (p_code_od) else $error("code pin driven high");
	property p_sel_od; bus_freq_select_o == 2'h0; endproperty
	a_sel_od: assert property (p_sel_od) else $error("select pin driven high");
	property p_rise; $rose(term_supply_good) |=> codes_stable; endproperty
	a_rise: assert property (p_rise) else $error("stable late");
	property p_fall; !term_supply_good |=> !codes_stable; endproperty
	a_fall: assert property (p_fall) else $error("stable after drop");
	property p_hold;
		codes_stable ##1 codes_stable ##1 codes_stable |-> $stable(supply_code_oe);
	endproperty
	a_hold: assert property (p_hold) else $error("code moved while stable");
	property p_sel; $past(codes_stable) && codes_stable |-> bus_freq_select_oe == 2'h2; endproperty
	a_sel: assert property (p_sel) else $error("select not 100 MHz");
	property p_rdata; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule : scf_supply_code_sva
bind scf_supply_code scf_supply_code_sva chk_u (.sys_clk, .reset, .term_supply_good, .reg_rd,
	.reg_rdata, .supply_code_o, .supply_code_oe, .bus_freq_select_o, .bus_freq_select_oe,
	.codes_stable);

//--- verif/scf_vreg_model.sv
// partner: regulator and clock generator latching the codes
`timescale 1ns/1ps
module scf_vreg_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// board levels
	input wire logic term_supply_good,
	input wire logic [4:0] code_pin,
	input wire logic [1:0] sel_pin,
	// latched result, 0 means off
	output int mv,
	output int mhz
);
	// interrupt clock and data pull-ups are board level, nothing here reads them
	logic [1:0] sync_r;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sync_r <= 2'h0;
			mv <= 0;
			mhz <= 0;
		end else begin
			sync_r <= {sync_r[0], term_supply_good};
			if (!sync_r[1]) begin
				mv <= 0;
				mhz <= 0;
			end else if (mv == 0) begin
				// coarse steps of 50, fine bit adds 25
				mv <= (code_pin[3:0] > 4'h4 ? 2050 : 1250) - 50 * int'(code_pin[3:0])
					+ (code_pin[4] ? 25 : 0);
				mhz <= (sel_pin == 2'h1) ? 100 : 0;
			end
		end
	end
endmodule : scf_vreg_model

//--- verif/scf_supply_code_test.sv
// testbench: register and power-good sequences for the supply code block
`timescale 1ns/1ps
module scf_supply_code_test;
	import scf_pkg::*;
	// supply good rests at its deasserted level until a test raises it
	logic sys_clk = 0, reset = 1, term_supply_good = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [4:0] supply_code_o, supply_code_oe;
	logic [1:0] bus_freq_select_o, bus_freq_select_oe;
	logic codes_stable;
	int mv, mhz, num_errors = 0, compares = 0, cycles = 0;
	// open drain with pull-up: released bit reads 1
	wire logic [4:0] code_pin = ~supply_code_oe | supply_code_o;
	wire logic [1:0] sel_pin = ~bus_freq_select_oe | bus_freq_select_o;
	scf_supply_code #(.SETTLE(2)) dut_u (.*);
	scf_vreg_model vreg_u (.sys_clk, .reset, .term_supply_good, .code_pin, .sel_pin, .mv, .mhz);
	always #5 sys_clk = ~sys_clk;
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] e, input string n);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(n, reg_rdata, e);
	endtask : rd
	task finish_test;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			finish_test;
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		rd(SCF_ADDR_CODE, 32'h8, "code cfg");
		rd(SCF_ADDR_SEL, 32'h1, "sel cfg");
		rd(4'h9, 32'h0, "unmapped");
		chk("code pin", code_pin, 32'h8);
		$display("reset test done");
		wr(SCF_ADDR_CODE, 32'h15);
		wr(SCF_ADDR_SEL, 32'h2);
		repeat (3) @(posedge sys_clk);
		term_supply_good <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk("volts", mv, 1825);
		chk("freq", mhz, 100);
		rd(SCF_ADDR_STAT, 32'hb, "status");
		wr(SCF_ADDR_STAT, 32'h2);
		rd(SCF_ADDR_STAT, 32'h9, "err clear");
		wr(SCF_ADDR_CODE, 32'h4);
		repeat (3) @(posedge sys_clk);
		chk("frozen pin", code_pin, 32'h15);
		rd(SCF_ADDR_PINS, 32'h35, "pins");
		$display("lock test done");
		term_supply_good <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk("off", mv, 0);
		chk("new pin", code_pin, 32'h4);
		term_supply_good <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk("volts", mv, 1050);
		$display("relock test done");
		finish_test;
	end
endmodule : scf_supply_code_test
